// ==== bench/pwm_pin_chk_sva.sv ====
`timescale 1ns/100ps
module pwm_pin_chk (
	input wire       clk_sys,
	input wire       rst_n,
	input wire [7:0] first_control_reg,
	input wire [7:0] third_control_reg,
	input wire [3:0] port_direction,
	input wire [3:0] port_output_data,
	input wire [3:0] pin_in,
	input wire [3:0] pin_pullup_en,
	input wire [3:0] pin_out,
	input wire [3:0] pin_oe,
	input wire [3:0] pin_pullup_on,
	input wire [3:0] pin_to_port,
	input wire [3:0] pwm_active
);
	reg [2:0] settle_r;
	// Pin input goes through a synchroniser, so only a settled level is compared
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			settle_r <= 3'h0;
		end else if (settle_r != 3'h7) begin
			settle_r <= settle_r + 3'h1;
		end
	end
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	pass_a: assert property ((settle_r == 3'h7 && $stable(pin_in)) [*5] |-> pin_to_port == pin_in)
		else $error("pass");
	pull_a: assert property (pin_pullup_on == (pin_pullup_en & port_direction))
		else $error("pull");
	sel_zero_a: assert property (pwm_active[0] == (first_control_reg[3] & ~port_direction[0]))
		else $error("sel0");
	sel_rest_a: assert property (pwm_active[3:1] == (third_control_reg[2:0] & ~port_direction[3:1]))
		else $error("sel");
	// Two cycles held, since the pin is registered
	gate_low_a: assert property ((pwm_active[0] && !port_output_data[0]) [*2] |-> !pin_out[0])
		else $error("gate");
	in_mode_a: assert property ((first_control_reg[3] && port_direction[0]) [*2] |-> !pin_oe[0])
		else $error("oe");
	drive_on_a: assert property (pwm_active[0] |=> pin_oe[0]) else $error("drv");
	io_data_a: assert property (!first_control_reg[3] |=> pin_out[0] == $past(port_output_data[0]))
		else $error("io");
endmodule
bind split_cycle_pwm pwm_pin_chk pwm_pin_chk_i (.*);

// ==== bench/testbench.sv ====
`timescale 1ns/100ps
module testbench;
	reg        clk_sys = 1'b0;
	reg        rst_n = 1'b0;
	reg  [7:0] duty = 8'h00;
	reg  [7:0] ca = 8'h00;
	reg  [3:0] dir = 4'hf;
	reg  [3:0] dat = 4'h0;
	reg  [3:0] pin = 4'h5;
	wire [3:0] po, oe, pu, tp, act;
	integer    n_mismatch = 0;
	integer    checks_done = 0;
	integer    tot, ris, mx, run, k;
	split_cycle_pwm split_cycle_pwm_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.duty_value_ch0(duty), .duty_value_ch1(duty), .duty_value_ch2(duty),
		.duty_value_ch3(duty), .first_control_reg(ca), .third_control_reg(ca),
		.port_direction(dir), .port_output_data(dat), .pin_in(pin),
		.pin_pullup_en(dat), .pin_out(po), .pin_oe(oe), .pin_pullup_on(pu),
		.pin_to_port(tp), .pwm_active(act));
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	task chk(input [23:0] nm, input [8:0] seen, input [8:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("[ERR] %0s exp %0d seen %0d", nm, exp, seen);
			end
		end
	endtask
	// Two full cycles, so any start phase gives exact totals
	task meas;
		begin
			repeat (600) @(negedge clk_sys);
			{tot, ris, mx} = 0;
			run = po[0];
			for (k = 0; k < 512; k = k + 1) begin
				@(negedge clk_sys);
				ris = ris + (po[0] && run == 0);
				run = po[0] ? run + 1 : 0;
				tot = tot + po[0];
				mx = run > mx ? run : mx;
			end
		end
	endtask
	task t_four;
		begin
			duty = 8'h0b;
			ca = 8'h08;
			dir = 4'hc;
			dat = 4'h1;
			meas;
			chk("tot", tot, 22);
			chk("ris", ris, 8);
			chk("max", mx, 3);
		end
	endtask
	task t_two;
		begin
			duty = 8'h65;
			ca = 8'h28;
			meas;
			chk("tot", tot, 202);
			chk("ris", ris, 4);
			chk("max", mx, 51);
		end
	endtask
	task t_gate;
		begin
			dat = 4'h0;
			meas;
			chk("off", tot, 0);
			dir = 4'hd;
			repeat (4) @(negedge clk_sys);
			chk("oe", oe[0], 0);
			pin = 4'ha;
			repeat (6) @(negedge clk_sys);
			chk("tp", tp, 10);
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", checks_done, n_mismatch);
			if (n_mismatch == 0 && checks_done > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	initial begin
		repeat (20) @(negedge clk_sys);
		rst_n = 1'b1;
		t_four;
		t_two;
		t_gate;
		complete_run;
	end
	initial begin
		#100000;
		n_mismatch = n_mismatch + 1;
		complete_run;
	end
endmodule

// ==== design/pwm_channel.v ====
`timescale 1ns/100ps
`include "split_cycle_pwm_defines.vh"

module pwm_channel (
	input  wire       clk_sys,
	input  wire       rst_n,
	input  wire [7:0] phase,
	input  wire       split2,
	input  wire [7:0] duty_value_reg,
	output reg        wave_r
);

	reg  [7:0] duty_live_r;
	reg  [6:0] base_high_count;
	reg  [1:0] extra_clock_count;
	reg  [6:0] sub_pos;
	reg  [1:0] sub_idx;
	reg  [7:0] high_len;
	reg        wave_nxt;

	// Latched only at the full-cycle boundary so a sub-cycle never glitches
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			duty_live_r <= `DUTY_RESET;
		end else if (phase == `PWM_LAST_PHASE) begin
			duty_live_r <= duty_value_reg;
		end
	end

	always @* begin
		if (split2) begin
			base_high_count   = duty_live_r[7:1];
			extra_clock_count = {1'b0, duty_live_r[0]};
			sub_pos           = phase[6:0];
			sub_idx           = {1'b0, phase[7]};
		end else begin
			base_high_count   = {1'b0, duty_live_r[7:2]};
			extra_clock_count = duty_live_r[1:0];
			sub_pos           = {1'b0, phase[5:0]};
			sub_idx           = phase[7:6];
		end
		high_len = {1'b0, base_high_count} + ((sub_idx < extra_clock_count) ? 8'h01 : 8'h00);
		wave_nxt = ({1'b0, sub_pos} < high_len);
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wave_r <= 1'b0;
		end else begin
			wave_r <= wave_nxt;
		end
	end

endmodule

// ==== design/split_cycle_pwm.v ====
`timescale 1ns/100ps
`include "split_cycle_pwm_defines.vh"

// Functional notes
// - Each channel holds 8-bit duty; full cycle is 256 system clocks.
// - Modulator counter runs straight from the system clock, no prescaler.
// - Four-way mode splits the cycle into four 64-clock sub-cycles.
// - Four-way mode: duty[7:2] is base count, duty[1:0] extra count.
// - Four-way: sub-cycle i high base+1 when i below extra, else base.
// - Two-way mode splits the cycle into two 128-clock sub-cycles.
// - Two-way mode: duty[7:1] is base count, duty[0] extra count.
// - Two-way: sub-cycle i high base+1 when i below extra, else base.
// - Split mode and per-channel enable come from two control registers.
// - Hardware splits sub-cycles and spreads extra clocks; software writes settings.
// - First control bit 5 picks two-way mode; bit 3 routes channel 0.
// - Waveform reaches pin only if selected and direction bit is output.
// - Selected output pin: data 1 passes waveform, data 0 drives low.
// - Selected but direction input: pin is ordinary input, pull-up only if pin_pullup_en.
module split_cycle_pwm #(
	parameter CHANNELS = 4
) (
	input  wire       clk_sys,
	input  wire       rst_n,
	input  wire [7:0] duty_value_ch0,
	input  wire [7:0] duty_value_ch1,
	input  wire [7:0] duty_value_ch2,
	input  wire [7:0] duty_value_ch3,
	input  wire [7:0] first_control_reg,
	input  wire [7:0] third_control_reg,
	input  wire [3:0] port_direction,
	input  wire [3:0] port_output_data,
	input  wire [3:0] pin_in,
	input  wire [3:0] pin_pullup_en,
	output reg  [3:0] pin_out,
	output reg  [3:0] pin_oe,
	output wire [3:0] pin_pullup_on,
	output wire [3:0] pin_to_port,
	output wire [3:0] pwm_active
);

	////////////////////////////////////////////////////////////////////////



	localparam ROLE_PORT     = 2'h0;
	localparam ROLE_PORT_IN  = 2'h1;
	localparam ROLE_PWM_OFF  = 2'h2;
	localparam ROLE_PWM_ON   = 2'h3;







	reg  [7:0] phase_r;

	reg  [7:0] phase_nxt;

	wire       split2;







	wire [3:0] wave;

	wire [3:0] fn_sel;

	wire [3:0] drive_nxt;

	wire [3:0] enable_nxt;

	wire [7:0] duty_bus [0:3];







	reg  [3:0] pin_meta_r;

	reg  [3:0] pin_sync_r;

	reg  [3:0] pin_hold_r;

	reg  [3:0] pin_level_r;

	reg  [3:0] pin_level_nxt;

	wire [3:0] pin_agree;







	////////////////////////////////////////////////////////////////////////

	// Channel select decode, shared by every pin of the mux
	function fn_select;

		input integer ch;

		input [7:0]   ctrl_a;

		input [7:0]   ctrl_c;

		begin
			case (ch)
				0: begin
					fn_select = ctrl_a[`CTRL_A_CH0_SEL_BIT];
				end

				1: begin
					fn_select = ctrl_c[`CTRL_C_CH1_SEL_BIT];
				end

				2: begin
					fn_select = ctrl_c[`CTRL_C_CH2_SEL_BIT];
				end

				default: begin
					fn_select = ctrl_c[`CTRL_C_CH3_SEL_BIT];
				end
			endcase
		end
	endfunction







	// Role of one pin from its select, direction and data bits
	function [1:0] pin_role;

		input sel;

		input dir_in;

		input data;

		begin
			if (!sel) begin
				pin_role = ROLE_PORT;
			end else if (dir_in) begin
				pin_role = ROLE_PORT_IN;
			end else if (!data) begin
				pin_role = ROLE_PWM_OFF;
			end else begin
				pin_role = ROLE_PWM_ON;
			end
		end
	endfunction







	// Level for the pin driver; the data bit gates the waveform
	function pin_drive;

		input [1:0] role;

		input       data;

		input       wave_in;

		begin
			case (role)
				ROLE_PORT: begin
					pin_drive = data;
				end

				ROLE_PORT_IN: begin
					pin_drive = 1'b0;
				end

				ROLE_PWM_OFF: begin
					pin_drive = 1'b0;
				end

				ROLE_PWM_ON: begin
					pin_drive = wave_in;
				end

				default: begin
					pin_drive = 1'b0;
				end
			endcase
		end
	endfunction






	////////////////////////////////////////////////////////////////////////

	assign duty_bus[0] = duty_value_ch0;

	assign duty_bus[1] = duty_value_ch1;

	assign duty_bus[2] = duty_value_ch2;

	assign duty_bus[3] = duty_value_ch3;

	// One mode bit serves every channel
	assign split2 = first_control_reg[`CTRL_A_SPLIT2_BIT];






	// Wraps every 256 clocks; no prescaler so cycle rate is clock/256
	always @* begin
		phase_nxt = phase_r + 8'h01;
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= 8'h00;
		end else begin
			phase_r <= phase_nxt;
		end
	end






	////////////////////////////////////////////////////////////////////////

	genvar g;

	generate
		for (g = 0; g < CHANNELS; g = g + 1) begin : ch
			assign fn_sel[g] = fn_select(g, first_control_reg, third_control_reg);

			pwm_channel u_ch (
				.clk_sys        (clk_sys),
				.rst_n          (rst_n),
				.phase          (phase_r),
				.split2         (split2),
				.duty_value_reg (duty_bus[g]),
				.wave_r         (wave[g])
			);

			assign drive_nxt[g] = pin_drive(
				pin_role(fn_sel[g], port_direction[g], port_output_data[g]),
				port_output_data[g],
				wave[g]);

			assign enable_nxt[g] = ~port_direction[g];
		end
	endgenerate






	////////////////////////////////////////////////////////////////////////

	// Three stages; a level counts only once the last two agree
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_r <= 4'h0;
		end else begin
			pin_meta_r <= pin_in;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_sync_r <= 4'h0;
		end else begin
			pin_sync_r <= pin_meta_r;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_hold_r <= 4'h0;
		end else begin
			pin_hold_r <= pin_sync_r;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_level_r <= 4'h0;
		end else begin
			pin_level_r <= pin_level_nxt;
		end
	end

	assign pin_agree = ~(pin_sync_r ^ pin_hold_r);

	always @* begin
		pin_level_nxt = (pin_level_r & ~pin_agree) | (pin_hold_r & pin_agree);
	end






	////////////////////////////////////////////////////////////////////////

	// Pin mux; when direction is input the pin is plain GPIO input
	assign pwm_active    = fn_sel & ~port_direction;

	assign pin_pullup_on = pin_pullup_en & port_direction;

	assign pin_to_port   = pin_level_r;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_oe <= 4'h0;
		end else begin
			pin_oe <= enable_nxt;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= 4'h0;
		end else begin
			pin_out <= drive_nxt;
		end
	end

endmodule

// ==== design/split_cycle_pwm_defines.vh ====
`ifndef SPLIT_CYCLE_PWM_DEFINES_VH
`define SPLIT_CYCLE_PWM_DEFINES_VH

// Full cycle and sub-cycle lengths in system clocks
`define PWM_FULL_CYCLE      9'h0100
`define PWM_SUB4_LEN        8'h40
`define PWM_SUB2_LEN        8'h80
`define PWM_LAST_PHASE      8'hFF

// First control register fields
`define CTRL_A_SPLIT2_BIT   5
`define CTRL_A_CH0_SEL_BIT  3

// Third control register fields (channels 1..3 function select)
`define CTRL_C_CH1_SEL_BIT  0
`define CTRL_C_CH2_SEL_BIT  1
`define CTRL_C_CH3_SEL_BIT  2

// Reset values
`define DUTY_RESET          8'h00
`define CTRL_RESET          8'h00
`define PORT_DIR_RESET      1'b1
`define PORT_DATA_RESET     1'b0

`endif
